// file: hw/sarc_bit_timer.sv
// Purpose: internal decision clock, restarted on every accepted start
// Assumes: restart and run are synchronous to core_clk
// Notes: tick pulses once per decision period while run is high
`timescale 1ns/1ps
module sarc_bit_timer
  import sarc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // control
  input wire logic restart,
  input wire logic run,
  // decision strobe
  output logic tick
);

  logic [7:0] cnt_r;

  // count restarts at the start so the clock stays phase locked to it
  always_ff @(posedge core_clk)
  begin
    if (srst || restart || !run)
    begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end
    else if (cnt_r == 8'(SARC_BIT_CYC - 1))
    begin
      cnt_r <= 8'h00;
      tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 8'h01;
      tick <= 1'b0;
    end
  end

endmodule : sarc_bit_timer

// file: hw/sarc_pkg.sv
// Purpose: shared constants and types for the sar conversion sequencer
// Assumes: core clock of 50 MHz
// Notes: all timing counts derive from printed times and the clock rate
package sarc_pkg;

  localparam int SARC_NBITS = 12;
  localparam int SARC_CLK_PERIOD_NS = 20;
  // acquire interval before the next start, as printed
  localparam int SARC_ACQ_NS = 200;
  // least time, rounded up to whole cycles
  localparam int SARC_ACQ_CYC = (SARC_ACQ_NS + SARC_CLK_PERIOD_NS - 1) / SARC_CLK_PERIOD_NS;
  // internal clock period of one bit decision
  localparam int SARC_BIT_NS = 120;
  localparam int SARC_BIT_CYC_RAW = SARC_BIT_NS / SARC_CLK_PERIOD_NS;
  localparam int SARC_BIT_CYC = (SARC_BIT_CYC_RAW < 1) ? 1 : SARC_BIT_CYC_RAW;
  localparam logic [3:0] SARC_LAST_BIT = 4'h0;
  localparam logic [3:0] SARC_FIRST_BIT = 4'hb;
  localparam logic [11:0] SARC_SAR_RST = 12'h000;
  localparam logic [11:0] SARC_MSB_MASK = 12'h800;

  // analog switch controls handed to the front end
  typedef struct packed {
    logic input_to_cap;   // sample cap connected to analog input
    logic fb_closed;      // comparator feedback switch closed (offset null)
  } sarc_sw_t;

  // finished result handed to the output latches
  typedef struct packed {
    logic bipolar;
    logic [11:0] code;
  } sarc_result_t;

endpackage : sarc_pkg

// file: hw/sarc_sequencer.sv
// Purpose: control logic of a 12-bit successive approximation converter
// Assumes: inputs synchronous to core_clk; comparator settles within one decision period
// Notes: start falls on convert_request_low while select_low is low
//
// Notes on behaviour
// - start only by select plus convert request
// - clear approximation register at each start
// - ignore start requests while converting
// - trial bits msb to lsb on dac
// - keep or clear trial bit by comparator
// - acquire: input to cap, feedback closed
// - convert: feedback open, cap to ground
// - load whole word into output latches once
// - return to acquire after last decision
// - unipolar result is straight binary
// - bipolar result is two's complement
// - falling convert request, select low, starts
// - busy low throughout conversion
`timescale 1ns/1ps
module sarc_sequencer
  import sarc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // host control
  input wire logic select_low,
  input wire logic convert_request_low,
  input wire logic bipolar_mode,
  // comparator: high when held input reaches or exceeds dac trial charge
  input wire logic comp_above,
  // analog front end controls
  output sarc_sw_t sw_ctrl,
  output logic [11:0] dac_code,
  // status and result
  output logic busy_low,
  output sarc_result_t result,
  output logic result_valid
);

  typedef enum logic [2:0] {
    SARC_ACQ  = 3'b001,
    SARC_CONV = 3'b010,
    SARC_LOAD = 3'b100
  } sarc_state_t;

  sarc_state_t state_r, state_nxt;
  logic req_d_r;
  logic start;
  logic tick;
  logic [11:0] sar_r;
  logic [3:0] bit_idx_r;

  // one-hot trial mask for a bit position
  function automatic logic [11:0] sarc_mask(input logic [3:0] idx);
    sarc_mask = SARC_MSB_MASK >> (SARC_FIRST_BIT - idx);
  endfunction : sarc_mask

  // previous request level for edge detection
  always_ff @(posedge core_clk)
  begin
    if (srst)
      req_d_r <= 1'b1;
    else
      req_d_r <= convert_request_low;
  end

  // falling edge qualified by select; only honoured in acquire
  assign start = req_d_r && !convert_request_low && !select_low
                 && (state_r == SARC_ACQ);

  sarc_bit_timer u_timer (
    .core_clk(core_clk),
    .srst(srst),
    .restart(start),
    .run(state_r == SARC_CONV),
    .tick(tick)
  );

  // sequencing; back-to-back spacing is left to the host
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SARC_ACQ:
        if (start)
          state_nxt = SARC_CONV;
      SARC_CONV:
        if (tick && bit_idx_r == SARC_LAST_BIT)
          state_nxt = SARC_LOAD;
      SARC_LOAD:
        state_nxt = SARC_ACQ;
      default:
        state_nxt = SARC_ACQ;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      state_r <= SARC_ACQ;
    else
      state_r <= state_nxt;
  end

  // approximation register: cleared, then one decision per period
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sar_r <= SARC_SAR_RST;
      bit_idx_r <= SARC_FIRST_BIT;
    end
    else if (start)
    begin
      sar_r <= SARC_SAR_RST;
      bit_idx_r <= SARC_FIRST_BIT;
    end
    else if (state_r == SARC_CONV && tick)
    begin
      if (comp_above)
        sar_r <= sar_r | sarc_mask(bit_idx_r);
      if (bit_idx_r != SARC_LAST_BIT)
        bit_idx_r <= bit_idx_r - 4'h1;
    end
  end

  // dac sees kept bits plus the bit under trial
  always_ff @(posedge core_clk)
  begin
    if (srst)
      dac_code <= SARC_SAR_RST;
    else if (start)
      dac_code <= SARC_MSB_MASK;
    else if (state_r == SARC_CONV && tick)
    begin
      if (bit_idx_r == SARC_LAST_BIT)
        dac_code <= comp_above ? (sar_r | sarc_mask(bit_idx_r)) : sar_r;
      else
        dac_code <= (comp_above ? (sar_r | sarc_mask(bit_idx_r)) : sar_r)
                    | sarc_mask(bit_idx_r - 4'h1);
    end
  end

  // switches flip together with busy, so the input is never sampled mid conversion
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sw_ctrl.input_to_cap <= 1'b1;
      sw_ctrl.fb_closed <= 1'b1;
      busy_low <= 1'b1;
    end
    else if (start)
    begin
      sw_ctrl.input_to_cap <= 1'b0;
      sw_ctrl.fb_closed <= 1'b0;
      busy_low <= 1'b0;
    end
    else if (state_r == SARC_LOAD)
    begin
      sw_ctrl.input_to_cap <= 1'b1;
      sw_ctrl.fb_closed <= 1'b1;
      busy_low <= 1'b1;
    end
  end

  // output latches: single load; bipolar flips msb of offset-binary sar
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      result <= '0;
      result_valid <= 1'b0;
    end
    else if (state_r == SARC_LOAD)
    begin
      result.bipolar <= bipolar_mode;
      result.code <= bipolar_mode ? (sar_r ^ SARC_MSB_MASK)
                                  : sar_r;
      result_valid <= 1'b1;
    end
    else
      result_valid <= 1'b0;
  end

endmodule : sarc_sequencer

// file: tb/sar_conversion_sequencer_tb.sv
// Purpose: self-checking bench for sarc_sequencer
// Assumes: 50 MHz clock, comparator model as analog side
// Notes: inputs move on the falling edge
`timescale 1ns/1ps
module sar_conversion_sequencer_tb
  import sarc_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic select_low = 1'b0;
  logic convert_request_low = 1'b1;
  logic bipolar_mode = 1'b0;
  logic [11:0] held_level = 12'h000;
  logic comp_above;
  sarc_sw_t sw_ctrl;
  logic [11:0] dac_code;
  logic busy_low;
  sarc_result_t result;
  logic result_valid;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  // rows: bipolar, held level, expected code
  logic [24:0] rows [4] = '{25'h0000000, 25'h0ffffff, 25'h1000800, 25'h1a5c25c};
  // clock
  initial forever #10 core_clk = ~core_clk;
  sarc_sequencer u_dut (.core_clk(core_clk), .srst(srst), .select_low(select_low),
    .convert_request_low(convert_request_low), .bipolar_mode(bipolar_mode),
    .comp_above(comp_above), .sw_ctrl(sw_ctrl), .dac_code(dac_code),
    .busy_low(busy_low), .result(result), .result_valid(result_valid));
  sarc_comp_model u_comp (.dac_code(dac_code), .held_level(held_level),
    .comp_above(comp_above));
  task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask : chk
  task automatic end_sim;
    if (bad_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // short pulse, back high before the first decision
  task automatic pulse;
    convert_request_low = 1'b0;
    repeat (2) @(negedge core_clk);
    convert_request_low = 1'b1;
    // one high cycle, so a pulse that follows at once still shows a falling edge
    @(negedge core_clk);
  endtask : pulse
  // bounded wait for the end, then the acquire gap
  task automatic wait_done;
    for (int i = 0; i < 100 && busy_low !== 1'b1; i++) @(negedge core_clk);
    chk("done", 13'h1, {12'h0, busy_low});
    repeat (10) @(negedge core_clk);
  endtask : wait_done
  // hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      end_sim;
    end
  end
  // main sequence
  initial
  begin
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    chk("reset", 13'h1000, {busy_low, result.code});
    foreach (rows[i])
    begin
      {bipolar_mode, held_level} = rows[i][24:12];
      pulse();
      chk("busy", 13'h0, {10'h0, busy_low, sw_ctrl});
      wait_done();
      chk("result", {rows[i][24], rows[i][11:0]}, result);
      chk("acquire", 13'h3, {11'h0, sw_ctrl});
    end
    select_low = 1'b1;
    pulse();
    chk("deselected", 13'h1, {12'h0, busy_low});
    select_low = 1'b0;
    bipolar_mode = 1'b0;
    held_level = 12'h3c5;
    pulse();
    repeat (20) @(negedge core_clk);
    pulse();
    // a restart on the second fall would keep busy low well past this point
    repeat (55) @(negedge core_clk);
    chk("no restart busy", 13'h1, {12'h0, busy_low});
    wait_done();
    chk("no restart", 13'h03c5, result);
    pulse();
    repeat (20) @(negedge core_clk);
    srst = 1'b1;
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    chk("reset mid", 13'h1000, {busy_low, result.code});
    end_sim();
  end
endmodule : sar_conversion_sequencer_tb

// file: tb/sarc_comp_model.sv
// Purpose: comparator with a held input level
// Assumes: ideal comparator, no offset
// Notes: the search settles on held_level
`timescale 1ns/1ps
module sarc_comp_model
(
  // trial and held level
  input wire logic [11:0] dac_code,
  input wire logic [11:0] held_level,
  // decision
  output logic comp_above
);
  // keep the trial when the held charge reaches it
  assign comp_above = (held_level >= dac_code);
endmodule : sarc_comp_model

// file: tb/sarc_seq_asserts.sv
// Purpose: port assertions for sarc_sequencer
// Assumes: one clock, sync reset
// Notes: bound to the top module
`timescale 1ns/1ps
module sarc_seq_asserts
  import sarc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // watched pins
  input wire logic select_low,
  input wire logic convert_request_low,
  input wire logic bipolar_mode,
  input wire sarc_sw_t sw_ctrl,
  input wire logic [11:0] dac_code,
  input wire logic busy_low,
  input wire sarc_result_t result,
  input wire logic result_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // a start needs a sampled fall while selected and idle
  sequence s_start;
    $fell(convert_request_low) && !select_low && busy_low;
  endsequence
  sequence s_desel;
    $fell(convert_request_low) && select_low && busy_low;
  endsequence
  a_start_taken: assert property (s_start |=> !busy_low && dac_code == 12'h800)
    else $error("start not taken");
  a_desel_ignored: assert property (s_desel |=> busy_low)
    else $error("start while deselected");
  a_switch_phase: assert property (sw_ctrl == {busy_low, busy_low})
    else $error("switches out of phase");
  a_busy_length: assert property ($fell(busy_low) |-> ##[72:76] $rose(busy_low))
    else $error("conversion length wrong");
  a_msb_first: assert property ($fell(busy_low) |-> (dac_code == 12'h800) [*5])
    else $error("msb trial not held");
  a_load_once: assert property (result_valid == $rose(busy_low))
    else $error("load strobe misplaced");
  a_result_hold: assert property (!result_valid |-> $stable(result))
    else $error("result changed without load");
  a_mode_taken: assert property (result_valid |-> result.bipolar == $past(bipolar_mode))
    else $error("result mode wrong");
endmodule : sarc_seq_asserts
bind sarc_sequencer sarc_seq_asserts u_chk (.core_clk(core_clk), .srst(srst),
  .select_low(select_low), .convert_request_low(convert_request_low),
  .bipolar_mode(bipolar_mode), .sw_ctrl(sw_ctrl), .dac_code(dac_code),
  .busy_low(busy_low), .result(result), .result_valid(result_valid));
